// *** hw/tcg_pkg.sv ***
// Shared constants for the timer clock gate and soft reset block.
// Assumes a 32-bit AHB-Lite register bus and one 100 MHz system clock.
package tcg_pkg;

   // Register byte addresses.
   localparam logic [31:0] TMR1_GATE_OFS = 32'h0000_0098;
   localparam logic [31:0] TMR1_SRST_OFS = 32'h0000_009C;
   localparam logic [31:0] TMR2_GATE_OFS = 32'h0000_00A0;
   localparam logic [31:0] TMR2_SRST_OFS = 32'h0000_00A4;

   // Field positions of the clock gate register.
   localparam int RUN_ON_BIT   = 0;
   localparam int SLEEP_ON_BIT = 8;
   localparam int DEEP_ON_BIT  = 16;

   // Field positions of the soft reset register.
   localparam int SOFT_RST_BIT = 0;
   localparam int EN_FLAG_BIT  = 1;

   // Readable bits, writable except soft reset bit 1; everything else reads zero.
   localparam logic [31:0] GATE_MASK = 32'h0001_0101;
   localparam logic [31:0] SRST_MASK = 32'h0000_0003;
   localparam logic [31:0] REG_RST   = 32'h0000_0000;
   localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

   // Timer reset is held during system reset.
   localparam logic TIMER_RST_INIT = 1'b1;

   // AHB-Lite encodings.
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic       HRESP_OKAY  = 1'b0;
   localparam logic       HREADY_INIT = 1'b1;

   // Power mode from the system power sequencer.
   typedef enum logic [1:0] {
      TCG_MODE_RUN   = 2'b00,
      TCG_MODE_SLEEP = 2'b01,
      TCG_MODE_DEEP  = 2'b10,
      TCG_MODE_OFF   = 2'b11
   } tcg_mode_t;

endpackage : tcg_pkg

// *** hw/tcg_timer_ctl.sv ***
// Clock gate and soft reset control for one timer instance.
// Assumes write strobes land in the bus data phase and pwr_mode is on mclk.
module tcg_timer_ctl (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire tcg_pkg::tcg_mode_t pwr_mode,
   input  wire logic              gate_wr,
   input  wire logic              srst_wr,
   input  wire logic [31:0]       wdata,
   output wire logic [31:0]       gate_rd,
   output wire logic [31:0]       srst_rd,
   output      logic              clk_en_ff,
   output      logic              timer_rst_ff
);

   logic run_clock_on_ff;
   logic sleep_clock_on_ff;
   logic deep_sleep_clock_on_ff;
   logic block_soft_reset_ff;

   wire logic nxt_run_clock_on        = gate_wr ? wdata[tcg_pkg::RUN_ON_BIT] : run_clock_on_ff;
   wire logic nxt_sleep_clock_on      = gate_wr ? wdata[tcg_pkg::SLEEP_ON_BIT] : sleep_clock_on_ff;
   wire logic nxt_deep_sleep_clock_on = gate_wr ? wdata[tcg_pkg::DEEP_ON_BIT] : deep_sleep_clock_on_ff;
   wire logic nxt_block_soft_reset    = srst_wr ? wdata[tcg_pkg::SOFT_RST_BIT] : block_soft_reset_ff;

   // The enable is picked from the settled registers and re-timed, so a mode change
   // only ever moves it on a clock edge and never produces a runt pulse.
   wire logic nxt_clk_en = (pwr_mode == tcg_pkg::TCG_MODE_RUN)   ? run_clock_on_ff :
                           (pwr_mode == tcg_pkg::TCG_MODE_SLEEP) ? sleep_clock_on_ff :
                           (pwr_mode == tcg_pkg::TCG_MODE_DEEP)  ? deep_sleep_clock_on_ff :
                           1'b0;

   wire logic block_enabled_flag = clk_en_ff & ~block_soft_reset_ff;

   // Read back shows pending writes so a read right behind a write sees it.
   assign gate_rd = ({31'h0000_0000, nxt_run_clock_on} << tcg_pkg::RUN_ON_BIT)
                  | ({31'h0000_0000, nxt_sleep_clock_on} << tcg_pkg::SLEEP_ON_BIT)
                  | ({31'h0000_0000, nxt_deep_sleep_clock_on} << tcg_pkg::DEEP_ON_BIT);
   assign srst_rd = ({31'h0000_0000, nxt_block_soft_reset} << tcg_pkg::SOFT_RST_BIT)
                  | ({31'h0000_0000, block_enabled_flag} << tcg_pkg::EN_FLAG_BIT);

   always_ff @(posedge mclk) begin
      if (rst) begin
         run_clock_on_ff        <= 1'b0;
         sleep_clock_on_ff      <= 1'b0;
         deep_sleep_clock_on_ff <= 1'b0;
         block_soft_reset_ff    <= 1'b0;
         clk_en_ff              <= 1'b0;
         timer_rst_ff           <= tcg_pkg::TIMER_RST_INIT;
      end else begin
         run_clock_on_ff        <= nxt_run_clock_on;
         sleep_clock_on_ff      <= nxt_sleep_clock_on;
         deep_sleep_clock_on_ff <= nxt_deep_sleep_clock_on;
         block_soft_reset_ff    <= nxt_block_soft_reset;
         clk_en_ff              <= nxt_clk_en;
         timer_rst_ff           <= block_soft_reset_ff;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_srst_set;
      srst_wr && wdata[tcg_pkg::SOFT_RST_BIT];
   endsequence

   chk_deep_gate: assert property ((pwr_mode == tcg_pkg::TCG_MODE_DEEP) |=> clk_en_ff == $past(deep_sleep_clock_on_ff))
      else $error("deep-sleep clock enable does not follow its bit");
   chk_sleep_gate: assert property ((pwr_mode == tcg_pkg::TCG_MODE_SLEEP) |=> clk_en_ff == $past(sleep_clock_on_ff))
      else $error("sleep clock enable does not follow its bit");
   chk_run_gate: assert property ((pwr_mode == tcg_pkg::TCG_MODE_RUN) |=> clk_en_ff == $past(run_clock_on_ff))
      else $error("run clock enable does not follow its bit");
   chk_srst_assert: assert property (s_srst_set |=> ##1 timer_rst_ff)
      else $error("timer reset not asserted two cycles after write of one");
   chk_srst_hold: assert property (block_soft_reset_ff && !srst_wr |=> ##1 timer_rst_ff)
      else $error("timer reset dropped while soft reset bit still set");
   chk_flag_low: assert property (block_soft_reset_ff |-> !srst_rd[tcg_pkg::EN_FLAG_BIT])
      else $error("enabled flag set while soft reset is held");
   chk_rsvd_zero: assert property (((gate_rd & ~tcg_pkg::GATE_MASK) == 32'h0000_0000)
                                   && ((srst_rd & ~tcg_pkg::SRST_MASK) == 32'h0000_0000))
      else $error("reserved bits read non-zero");
   chk_mode_off: assert property ((pwr_mode == tcg_pkg::TCG_MODE_OFF) |=> !clk_en_ff)
      else $error("clock enabled in an undefined power mode");

endmodule : tcg_timer_ctl

// *** hw/tcg_top.sv ***
// Top of the timer clock gate and soft reset block with its AHB-Lite slave.
// Assumes a single AHB-Lite master, word transfers only, and pwr_mode on mclk.
// Clock outputs are enables for a downstream gate cell next to each timer.
//
// The AHB-Lite interface to the registers was chosen for this implementation.

// Functional notes
// - In deep-sleep a timer's clock runs only when its deep-sleep enable bit 16 is one.
// - In sleep a timer's clock runs only when its sleep enable bit 8 is one.
// - In run mode a timer's clock runs only when its run enable bit 0 is one.
// - Writing one to soft reset bit 0 asserts the timer reset and writing zero releases it; it resets to zero.
// - Soft reset bit 1 is a read-only flag showing whether the timer's clock and reset are enabled.
// - All other clock gate bits and soft reset bits above bit 1 read zero and ignore writes.
// - The first timer's gate register sits at 98h and its soft reset register at 9Ch, both resetting to zero.
// - The second timer's gate register sits at A0h and soft reset at A4h, identical to the first.
module tcg_top (
   input  wire logic               mclk,
   input  wire logic               rst,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output wire logic               hreadyout,
   output wire logic [31:0]        hrdata,
   output wire logic               hresp,
   input  wire tcg_pkg::tcg_mode_t pwr_mode,
   output wire logic               timer1_clk_en,
   output wire logic               timer1_soft_rst,
   output wire logic               timer2_clk_en,
   output wire logic               timer2_soft_rst
);

   logic        hreadyout_ff;
   logic [31:0] hrdata_ff;
   logic        hresp_ff;
   logic        wr_pend_ff;
   logic [31:0] wr_addr_ff;

   wire logic [31:0] t1_gate_rd;
   wire logic [31:0] t1_srst_rd;
   wire logic [31:0] t2_gate_rd;
   wire logic [31:0] t2_srst_rd;

   // Address phase decode. Only whole-word singles are issued, so hsize is not
   // checked; a narrower access would still act on the full word.
   wire logic accept   = hsel & hready & (htrans != tcg_pkg::HTRANS_IDLE) & htrans[1];
   wire logic rd_start = accept & ~hwrite;
   wire logic wr_start = accept & hwrite;

   // Data phase write strobes, one per register.
   wire logic t1_gate_wr = wr_pend_ff & (wr_addr_ff == tcg_pkg::TMR1_GATE_OFS);
   wire logic t1_srst_wr = wr_pend_ff & (wr_addr_ff == tcg_pkg::TMR1_SRST_OFS);
   wire logic t2_gate_wr = wr_pend_ff & (wr_addr_ff == tcg_pkg::TMR2_GATE_OFS);
   wire logic t2_srst_wr = wr_pend_ff & (wr_addr_ff == tcg_pkg::TMR2_SRST_OFS);

   // Read selection; unmapped addresses read as zero with an OKAY response.
   wire logic [31:0] rd_mux =
      (haddr == tcg_pkg::TMR1_GATE_OFS) ? t1_gate_rd :
      (haddr == tcg_pkg::TMR1_SRST_OFS) ? t1_srst_rd :
      (haddr == tcg_pkg::TMR2_GATE_OFS) ? t2_gate_rd :
      (haddr == tcg_pkg::TMR2_SRST_OFS) ? t2_srst_rd :
      tcg_pkg::RD_ZERO;

   wire logic [31:0] nxt_hrdata  = rd_start ? rd_mux : tcg_pkg::RD_ZERO;
   wire logic        nxt_wr_pend = wr_start;
   wire logic [31:0] nxt_wr_addr = wr_start ? haddr : wr_addr_ff;

   assign hreadyout = hreadyout_ff;
   assign hrdata    = hrdata_ff;
   assign hresp     = hresp_ff;

   always_ff @(posedge mclk) begin
      if (rst) begin
         hreadyout_ff <= tcg_pkg::HREADY_INIT;
         hrdata_ff    <= tcg_pkg::RD_ZERO;
         hresp_ff     <= tcg_pkg::HRESP_OKAY;
         wr_pend_ff   <= 1'b0;
         wr_addr_ff   <= tcg_pkg::REG_RST;
      end else begin
         hreadyout_ff <= tcg_pkg::HREADY_INIT;
         hrdata_ff    <= nxt_hrdata;
         hresp_ff     <= tcg_pkg::HRESP_OKAY;
         wr_pend_ff   <= nxt_wr_pend;
         wr_addr_ff   <= nxt_wr_addr;
      end
   end

   // Both timers share one parameterless control slice; only the strobes differ.
   tcg_timer_ctl u_timer_instance_one (
      .mclk         (mclk),
      .rst          (rst),
      .pwr_mode     (pwr_mode),
      .gate_wr      (t1_gate_wr),
      .srst_wr      (t1_srst_wr),
      .wdata        (hwdata),
      .gate_rd      (t1_gate_rd),
      .srst_rd      (t1_srst_rd),
      .clk_en_ff    (timer1_clk_en),
      .timer_rst_ff (timer1_soft_rst)
   );

   tcg_timer_ctl u_timer_instance_two (
      .mclk         (mclk),
      .rst          (rst),
      .pwr_mode     (pwr_mode),
      .gate_wr      (t2_gate_wr),
      .srst_wr      (t2_srst_wr),
      .wdata        (hwdata),
      .gate_rd      (t2_gate_rd),
      .srst_rd      (t2_srst_rd),
      .clk_en_ff    (timer2_clk_en),
      .timer_rst_ff (timer2_soft_rst)
   );

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_wr_t1_gate;
      wr_start && (haddr == tcg_pkg::TMR1_GATE_OFS);
   endsequence

   sequence s_rd_t1_gate;
      rd_start && (haddr == tcg_pkg::TMR1_GATE_OFS);
   endsequence

   sequence s_wr_t2_srst;
      wr_start && (haddr == tcg_pkg::TMR2_SRST_OFS);
   endsequence

   sequence s_rd_t2_srst;
      rd_start && (haddr == tcg_pkg::TMR2_SRST_OFS);
   endsequence

   // A read right behind a write to the same register returns the new value.
   property p_t1_gate_bypass;
      logic [31:0] d;
      s_wr_t1_gate ##1 (s_rd_t1_gate, d = hwdata) |=> hrdata == (d & tcg_pkg::GATE_MASK);
   endproperty

   property p_t2_srst_bypass;
      logic [31:0] d;
      s_wr_t2_srst ##1 (s_rd_t2_srst, d = hwdata) |=> hrdata[tcg_pkg::SOFT_RST_BIT] == d[tcg_pkg::SOFT_RST_BIT];
   endproperty

   chk_t1_gate_map: assert property (p_t1_gate_bypass)
      else $error("first timer gate register not at its offset");
   chk_t2_srst_map: assert property (p_t2_srst_bypass)
      else $error("second timer soft reset register not at its offset");
   chk_t2_srst_out: assert property (s_wr_t2_srst ##1 hwdata[tcg_pkg::SOFT_RST_BIT] |=> ##1 timer2_soft_rst)
      else $error("second timer reset not asserted after write of one");
   chk_t1_srst_out: assert property (wr_start && (haddr == tcg_pkg::TMR1_SRST_OFS)
                                     ##1 !hwdata[tcg_pkg::SOFT_RST_BIT] |=> ##1 !timer1_soft_rst)
      else $error("first timer reset not released after write of zero");
   chk_unmapped_rd: assert property (rd_start && (haddr != tcg_pkg::TMR1_GATE_OFS)
                                     && (haddr != tcg_pkg::TMR1_SRST_OFS)
                                     && (haddr != tcg_pkg::TMR2_GATE_OFS)
                                     && (haddr != tcg_pkg::TMR2_SRST_OFS) |=> hrdata == 32'h0000_0000)
      else $error("unmapped address read non-zero");
   chk_bus_okay: assert property (hreadyout && (hresp == tcg_pkg::HRESP_OKAY))
      else $error("slave stalled or answered with an error");
   chk_t2_flag: assert property ((timer2_soft_rst and s_rd_t2_srst) |=> !hrdata[tcg_pkg::EN_FLAG_BIT])
      else $error("second timer enabled flag set while it is held in reset");
   chk_run_mode_t1: assert property ((pwr_mode == tcg_pkg::TCG_MODE_RUN)[*2] ##0 s_wr_t1_gate
                                     ##1 !hwdata[tcg_pkg::RUN_ON_BIT] ##1 (pwr_mode == tcg_pkg::TCG_MODE_RUN)
                                     |=> !timer1_clk_en)
      else $error("first timer clock still running after run enable cleared");
   // With no gate write and a steady mode the enable has no cause to move, so any change is a glitch.
   chk_mode_change: assert property (!t1_gate_wr ##1 $stable(pwr_mode) |=> $stable(timer1_clk_en))
      else $error("clock enable moved without a mode change or gate write");

endmodule : tcg_top

// *** tb/tcg_timer_model.sv ***
// Behavioural model of one timer that sits behind the gated clock enable.
// Assumes the enable and soft reset arrive registered on mclk.
module tcg_timer_model (
   input  wire logic        mclk,
   input  wire logic        clk_en,
   input  wire logic        soft_rst,
   output      logic [15:0] tick_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   initial tick_cnt = 16'h0000;
   // The count advances only on edges that the gate lets through, so a leaky gate shows up as drift.
   always @(posedge mclk) begin
      if (soft_rst === 1'b1) begin
         tick_cnt <= 16'h0000;
      end else if (clk_en === 1'b1) begin
         tick_cnt <= tick_cnt + 16'h0001;
      end
   end
endmodule : tcg_timer_model

// *** tb/testbench.sv ***
// Self-checking bench for the timer clock gate block, driven over AHB-Lite.
// Assumes zero wait states are not guaranteed: every bus phase waits for hready.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic               mclk = 1'b0;
   logic               rst, hsel, hwrite;
   logic [31:0]        haddr, hwdata, rdat;
   logic [1:0]         htrans;
   logic [2:0]         hsize;
   wire logic          hready;
   wire logic [31:0]   hrdata;
   wire logic          hresp;
   tcg_pkg::tcg_mode_t pwr_mode;
   wire logic [1:0]    en_w, srst_w;
   wire logic [15:0]   cnt [2];
   logic [31:0]        regs [4];
   logic [31:0]        gv [4];
   logic [15:0]        snap;
   logic               exp;
   int                 fail_count = 0;
   int                 n_tests = 0;

   always #5 mclk = ~mclk;

   tcg_top i_tcg_top (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
      .pwr_mode(pwr_mode), .timer1_clk_en(en_w[0]), .timer1_soft_rst(srst_w[0]),
      .timer2_clk_en(en_w[1]), .timer2_soft_rst(srst_w[1]));
   tcg_timer_model i_tcg_timer_model_a (.mclk(mclk), .clk_en(en_w[0]), .soft_rst(srst_w[0]), .tick_cnt(cnt[0]));
   tcg_timer_model i_tcg_timer_model_b (.mclk(mclk), .clk_en(en_w[1]), .soft_rst(srst_w[1]), .tick_cnt(cnt[1]));

   task automatic bus_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge mclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= addr;
      hwrite <= wr;
      do @(posedge mclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= tcg_pkg::HTRANS_IDLE;
      hwdata <= wd;
      do @(posedge mclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus_xfer

   // Write, then read the same register with its address phase inside the write's data phase.
   task automatic wr_rd(input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge mclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= addr;
      hwrite <= 1'b1;
      do @(posedge mclk); while (hready !== 1'b1);
      hwrite <= 1'b0;
      hwdata <= wd;
      do @(posedge mclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= tcg_pkg::HTRANS_IDLE;
      do @(posedge mclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : wr_rd

   task automatic chk32(input logic [31:0] got, input logic [31:0] want);
      n_tests++;
      if (got !== want) begin
         fail_count++;
         $display("[ERR] %0t word got %h expected %h", $time, got, want);
      end
   endtask : chk32

   task automatic chk1(input logic got, input logic want);
      n_tests++;
      if (got !== want) begin
         fail_count++;
         $display("[ERR] %0t bit got %b expected %b", $time, got, want);
      end
   endtask : chk1

   task automatic set_mode(input int m);
      @(posedge mclk);
      pwr_mode <= tcg_pkg::tcg_mode_t'(m[1:0]);
      repeat (3) @(negedge mclk);
   endtask : set_mode

   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test

   // The full run needs well under 2000 cycles; this bound only catches a stuck bus.
   initial begin
      repeat (5000) @(posedge mclk);
      fail_count++;
      stop_test();
   end

   initial begin
      regs = '{tcg_pkg::TMR1_GATE_OFS, tcg_pkg::TMR1_SRST_OFS, tcg_pkg::TMR2_GATE_OFS, tcg_pkg::TMR2_SRST_OFS};
      gv = '{32'h0000_0001, 32'h0000_0100, 32'h0001_0000, 32'h0000_0000};
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = tcg_pkg::HTRANS_IDLE;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      pwr_mode = tcg_pkg::TCG_MODE_RUN;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(negedge mclk);
      for (int i = 0; i < 4; i++) begin
         bus_xfer(1'b0, regs[i], 32'h0000_0000, rdat);
         chk32(rdat, tcg_pkg::REG_RST);
      end
      for (int t = 0; t < 2; t++) begin
         bus_xfer(1'b1, regs[2*t], 32'hFFFF_FFFF, rdat);
         bus_xfer(1'b0, regs[2*t], 32'h0000_0000, rdat);
         chk32(rdat, tcg_pkg::GATE_MASK);
         bus_xfer(1'b1, regs[2*t+1], 32'hFFFF_FFFF, rdat);
         bus_xfer(1'b0, regs[2*t+1], 32'h0000_0000, rdat);
         chk32(rdat, 32'h0000_0001);
         repeat (6) @(negedge mclk);
         chk1(srst_w[t], 1'b1);
         chk32({16'h0000, cnt[t]}, 32'h0000_0000);
         bus_xfer(1'b1, regs[2*t+1], 32'h0000_0000, rdat);
         repeat (3) @(negedge mclk);
         chk1(srst_w[t], 1'b0);
         bus_xfer(1'b0, regs[2*t+1], 32'h0000_0000, rdat);
         chk32(rdat, 32'h0000_0002);
         snap = cnt[t];
         repeat (10) @(negedge mclk);
         chk32({16'h0000, cnt[t]}, {16'h0000, snap + 16'h000A});
      end
      for (int g = 0; g < 4; g++) begin
         bus_xfer(1'b1, regs[0], gv[g], rdat);
         bus_xfer(1'b1, regs[2], gv[g], rdat);
         for (int m = 0; m < 4; m++) begin
            set_mode(m);
            exp = (m != 3) && gv[g][m*8];
            chk1(en_w[0], exp);
            chk1(en_w[1], exp);
            bus_xfer(1'b0, regs[3], 32'h0000_0000, rdat);
            chk32(rdat, {30'h0000_0000, exp, 1'b0});
         end
      end
      // An address just below the first register must stay dead for both reads and writes.
      bus_xfer(1'b1, 32'h0000_0094, 32'hFFFF_FFFF, rdat);
      bus_xfer(1'b0, 32'h0000_0094, 32'h0000_0000, rdat);
      chk32(rdat, tcg_pkg::RD_ZERO);
      bus_xfer(1'b0, regs[0], 32'h0000_0000, rdat);
      chk32(rdat, 32'h0000_0000);
      set_mode(0);
      bus_xfer(1'b1, regs[0], 32'h0000_0001, rdat);
      repeat (3) @(negedge mclk);
      chk1(en_w[0], 1'b1);
      wr_rd(regs[0], 32'hFFFF_FEFE, rdat);
      chk32(rdat, 32'h0001_0000);
      chk1(hresp, tcg_pkg::HRESP_OKAY);
      repeat (3) @(negedge mclk);
      chk1(en_w[0], 1'b0);
      wr_rd(regs[3], 32'hFFFF_FFFF, rdat);
      chk1(rdat[0], 1'b1);
      repeat (3) @(negedge mclk);
      chk1(srst_w[1], 1'b1);
      bus_xfer(1'b1, regs[3], 32'h0000_0000, rdat);
      stop_test();
   end
endmodule : testbench
